// *** inc/msc_pkg.sv ***
// Operation
// [RL1] With the route select held low the test-access port is passed on to the SoC.
// [RL2] With the route select high or open the test-access port is taken by the controller.
// [RL3] The active-low power-on reset request from the carrier drives the SoC power-on reset.
// [RL4] The active-low processor system reset input drives the SoC processor system reset.
// [RL5] The lower boot strap output to the carrier connector stays high by default.
// [RL6] The active-low fabric supply enable output stays high by default.
// [RL7] The active-low fabric supply good input is sampled and watched.
// [RL8] The active-low processor supply good input is sampled and watched.
// [RL9] The status LED blinks while the controller runs.
// [RL10] The real-time clock interrupt line is an input that raises an event.
// [RL11] Straps upper,lower decode as 00 JTAG, 10 QSPI flash and 11 SD card.
// [RL12] The upper strap comes from the controller, the lower strap from the carrier.
// [RL13] QSPI flash boot, upper high and lower low, is the standard mode.
// [RL14] After reset the controller drives the upper strap to 1 and the port is cascaded.
// [RL15] The controller watches the power-on sequence and shows the fabric configuration state.
// [RL16] Reset, power-good and interrupt inputs pass two flip-flops before any logic.
// [RL17] The LED toggles from a clock divider at a visible rate of about twice a second; the divider toggles it every 500 ms.
`default_nettype none
package msc_pkg;
    // clock and timing
    localparam int unsigned CLK_HZ       = 50_000_000;
    localparam int unsigned LED_HALF_MS  = 500;
    localparam int unsigned LED_HALF_CYC = CLK_HZ / 1000 * LED_HALF_MS;
    localparam int unsigned POR_HOLD_US  = 10;
    localparam int unsigned POR_HOLD_CYC = (CLK_HZ / 1_000_000) * POR_HOLD_US;

    // register offsets
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h01;
    localparam logic [7:0] REG_EVENT  = 8'h02;
    localparam logic [7:0] REG_MASK   = 8'h03;

    // control fields and reset value
    localparam int unsigned CTRL_UPPER = 0;
    localparam int unsigned CTRL_LOWER = 1;
    localparam int unsigned CTRL_FEN_N = 2;
    localparam logic [2:0]  CTRL_RST   = 3'h7;

    // status fields
    localparam int unsigned ST_ROUTE  = 0;
    localparam int unsigned ST_FGOOD  = 1;
    localparam int unsigned ST_PGOOD  = 2;
    localparam int unsigned ST_DONE   = 3;
    localparam int unsigned ST_BOOT   = 4;
    localparam int unsigned ST_SEQ    = 6;

    // event fields
    localparam int unsigned EV_RTC   = 0;
    localparam int unsigned EV_FGOOD = 1;
    localparam int unsigned EV_PGOOD = 2;
    localparam int unsigned EV_POR   = 3;
    localparam int unsigned EV_PSR   = 4;
    localparam int unsigned EV_W     = 5;

    // synchroniser lanes and their idle values
    localparam int unsigned SY_ROUTE = 0;
    localparam int unsigned SY_POR   = 1;
    localparam int unsigned SY_PSR   = 2;
    localparam int unsigned SY_FGOOD = 3;
    localparam int unsigned SY_PGOOD = 4;
    localparam int unsigned SY_RTC   = 5;
    localparam int unsigned SY_DONE  = 6;
    localparam int unsigned SY_TCK   = 7;
    localparam int unsigned SY_TMS   = 8;
    localparam int unsigned SY_TDI   = 9;
    localparam int unsigned SY_STDO  = 10;
    localparam int unsigned SY_LOWER = 11;
    localparam int unsigned SY_W     = 12;
    localparam logic [11:0] SY_RST   = 12'h73F;

    // boot source decode of {upper, lower}
    typedef enum logic [1:0] {
        MSC_BOOT_JTAG = 2'h0,
        MSC_BOOT_BAD  = 2'h1,
        MSC_BOOT_QSPI = 2'h2,
        MSC_BOOT_SD   = 2'h3
    } msc_boot_t;

    // power-on sequence states, gray along the path
    typedef enum logic [1:0] {
        MSC_SEQ_WAIT = 2'h0,
        MSC_SEQ_HOLD = 2'h1,
        MSC_SEQ_RUN  = 2'h3
    } msc_seq_t;
endpackage
`default_nettype wire

// *** core/msc_sync.sv ***
`default_nettype none
// two-flop synchroniser, one lane per bit
module msc_sync #(
    parameter int unsigned W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         ref_clk,
    input  wire logic         rstn,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_q;
    logic [W-1:0] sync_d;

    // the first stage feeds only the second stage
    for (genvar i = 0; i < W; i++) begin : g_lane
        always_comb begin
            meta_d[i] = async_in[i];
            sync_d[i] = meta_q[i];
        end

        always_ff @(posedge ref_clk or negedge rstn) begin
            if (!rstn) begin
                meta_q[i] <= RST_VAL[i];
                sync_q[i] <= RST_VAL[i];
            end else begin
                meta_q[i] <= meta_d[i];
                sync_q[i] <= sync_d[i];
            end
        end
    end

    assign sync_out = sync_q;
endmodule
`default_nettype wire

// *** core/msc_top.sv ***
`default_nettype none
module msc_top
    import msc_pkg::*;
#(
    parameter int unsigned LED_HALF_CYC_P = LED_HALF_CYC
) (
    input  wire logic       ref_clk,
    input  wire logic       rstn,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    output logic            irq,
    input  wire logic       route_select,
    input  wire logic       carrier_tck,
    input  wire logic       carrier_tms,
    input  wire logic       carrier_tdi,
    output logic            carrier_tdo,
    output logic            soc_tck,
    output logic            soc_tms,
    output logic            soc_tdi,
    input  wire logic       soc_tdo,
    input  wire logic       por_request_n,
    output logic            soc_por_n,
    input  wire logic       processor_system_reset_in_n,
    output logic            soc_ps_reset_n,
    output logic            boot_strap_upper,
    output logic            boot_strap_lower,
    input  wire logic       strap_pin_lower,
    output logic            fabric_supply_enable_n,
    input  wire logic       fabric_supply_good_n,
    input  wire logic       processor_supply_good_n,
    input  wire logic       rtc_irq_n,
    input  wire logic       fabric_logic_done,
    output logic            status_led
);
    localparam logic [15:0] HOLD_LAST = 16'(POR_HOLD_CYC - 1);
    localparam logic [24:0] LED_LAST  = 25'(LED_HALF_CYC_P - 1);

    logic [SY_W-1:0] pin_s;
    logic            route_s;
    logic            por_s;
    logic            psr_s;
    logic            fgood_s;
    logic            pgood_s;
    logic            rtc_s;
    logic            done_s;
    logic            tck_s;
    logic            supplies_ok;
    msc_boot_t       boot_src;

    // every pin input crosses two flops before use
    msc_sync #(
        .W       (SY_W),
        .RST_VAL (SY_RST)
    ) u_sync (
        .ref_clk  (ref_clk),
        .rstn     (rstn),
        .async_in ({strap_pin_lower, soc_tdo, carrier_tdi, carrier_tms, carrier_tck,
                    fabric_logic_done, rtc_irq_n, processor_supply_good_n,
                    fabric_supply_good_n, processor_system_reset_in_n, por_request_n,
                    route_select}),
        .sync_out (pin_s)
    ); // [RL16]

    assign route_s     = pin_s[SY_ROUTE];
    assign por_s       = pin_s[SY_POR];
    assign psr_s       = pin_s[SY_PSR];
    assign fgood_s     = pin_s[SY_FGOOD];
    assign pgood_s     = pin_s[SY_PGOOD];
    assign rtc_s       = pin_s[SY_RTC];
    assign done_s      = pin_s[SY_DONE];
    assign tck_s       = pin_s[SY_TCK];
    assign supplies_ok = !fgood_s && !pgood_s; // [RL7] [RL8]

    // ---------------- test-access routing ----------------
    logic tck_q, tms_q, tdi_q, tdo_q, bypass_q, tck_prev_q;
    logic tck_d, tms_d, tdi_d, tdo_d, bypass_d;

    // pass-through is resampled, so the carrier must keep its test clock slow
    always_comb begin
        bypass_d = bypass_q;
        if (route_s && tck_s && !tck_prev_q) begin
            bypass_d = pin_s[SY_TDI]; // [RL2]
        end
        if (route_s) begin
            tck_d = 1'b0; // [RL2]
            tms_d = 1'b1;
            tdi_d = 1'b1;
            tdo_d = bypass_q;
        end else begin
            tck_d = tck_s; // [RL1]
            tms_d = pin_s[SY_TMS];
            tdi_d = pin_s[SY_TDI];
            tdo_d = pin_s[SY_STDO];
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            tck_q      <= 1'b0;
            tms_q      <= 1'b1;
            tdi_q      <= 1'b1;
            tdo_q      <= 1'b1;
            bypass_q   <= 1'b1; // same idle level as carrier_tdo in reset
            tck_prev_q <= 1'b0;
        end else begin
            tck_q      <= tck_d;
            tms_q      <= tms_d;
            tdi_q      <= tdi_d;
            tdo_q      <= tdo_d;
            bypass_q   <= bypass_d;
            tck_prev_q <= tck_s;
        end
    end

    assign soc_tck     = tck_q;
    assign soc_tms     = tms_q;
    assign soc_tdi     = tdi_q;
    assign carrier_tdo = tdo_q;

    // ---------------- power-on sequence ----------------
    msc_seq_t    seq_q, seq_d;
    logic [15:0] hold_q, hold_d;
    logic        por_q, por_d, psr_q, psr_d;

    // soc_por_n stays low until both supplies have settled; soc_ps_reset_n follows its input regardless
    always_comb begin
        seq_d  = seq_q;
        hold_d = hold_q;
        unique case (seq_q)
            MSC_SEQ_WAIT: begin
                hold_d = 16'h0000;
                if (supplies_ok) begin
                    seq_d = MSC_SEQ_HOLD; // [RL15]
                end
            end
            MSC_SEQ_HOLD: begin
                hold_d = hold_q + 16'h0001;
                if (!supplies_ok) begin
                    seq_d = MSC_SEQ_WAIT;
                end else if (hold_q == HOLD_LAST) begin
                    seq_d = MSC_SEQ_RUN;
                end
            end
            MSC_SEQ_RUN: begin
                if (!supplies_ok) begin
                    seq_d = MSC_SEQ_WAIT; // [RL15]
                end
            end
            default: begin
                seq_d = MSC_SEQ_WAIT;
            end
        endcase
        por_d = (seq_q == MSC_SEQ_RUN) && por_s; // [RL3]
        psr_d = psr_s; // [RL4]
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            seq_q  <= MSC_SEQ_WAIT;
            hold_q <= 16'h0000;
            por_q  <= 1'b0;
            psr_q  <= 1'b0;
        end else begin
            seq_q  <= seq_d;
            hold_q <= hold_d;
            por_q  <= por_d;
            psr_q  <= psr_d;
        end
    end

    assign soc_por_n      = por_q;
    assign soc_ps_reset_n = psr_q;

    // ---------------- activity LED ----------------
    logic [24:0] led_cnt_q, led_cnt_d;
    logic        led_q, led_d;

    // a free divider, so a stuck clock shows as a dark or lit LED
    always_comb begin
        led_cnt_d = led_cnt_q + 25'h0000001;
        led_d     = led_q;
        if (led_cnt_q == LED_LAST) begin
            led_cnt_d = 25'h0000000; // [RL17]
            led_d     = !led_q; // [RL9]
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            led_cnt_q <= 25'h0000000;
            led_q     <= 1'b0;
        end else begin
            led_cnt_q <= led_cnt_d;
            led_q     <= led_d;
        end
    end

    assign status_led = led_q;

    // ---------------- registers and events ----------------
    logic [2:0]      ctrl_q, ctrl_d;
    logic [EV_W-1:0] ev_q, ev_d, mask_q, mask_d, ev_new;
    logic [7:0]      rdata_q, rdata_d;
    logic            rtc_prev_q, fgood_prev_q, pgood_prev_q, por_prev_q, psr_prev_q;

    assign boot_src = msc_boot_t'({ctrl_q[CTRL_UPPER], pin_s[SY_LOWER]}); // [RL11] [RL12]

    // set wins over the clear-on-read
    always_comb begin
        ev_new           = '0;
        ev_new[EV_RTC]   = rtc_prev_q && !rtc_s; // [RL10]
        ev_new[EV_FGOOD] = fgood_prev_q != fgood_s; // [RL7]
        ev_new[EV_PGOOD] = pgood_prev_q != pgood_s; // [RL8]
        ev_new[EV_POR]   = por_prev_q && !por_s;
        ev_new[EV_PSR]   = psr_prev_q && !psr_s;
        ctrl_d  = ctrl_q;
        mask_d  = mask_q;
        ev_d    = ev_q;
        rdata_d = 8'h00;
        if (reg_wr && reg_addr == REG_CTRL) begin
            ctrl_d = reg_wdata[2:0];
        end
        if (reg_wr && reg_addr == REG_MASK) begin
            mask_d = reg_wdata[EV_W-1:0];
        end
        if (reg_rd) begin
            unique case (reg_addr)
                REG_CTRL:   rdata_d = {5'h00, ctrl_q};
                REG_STATUS: rdata_d = {seq_q, boot_src, done_s, pgood_s, fgood_s, route_s};
                REG_EVENT:  rdata_d = {3'h0, ev_q};
                REG_MASK:   rdata_d = {3'h0, mask_q};
                default:    rdata_d = 8'h00;
            endcase
            if (reg_addr == REG_EVENT) begin
                ev_d = '0;
            end
        end
        ev_d = ev_d | ev_new;
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_q       <= CTRL_RST; // [RL5] [RL6] [RL14]
            mask_q       <= '0;
            ev_q         <= '0;
            rdata_q      <= 8'h00;
            rtc_prev_q   <= 1'b1;
            fgood_prev_q <= 1'b1;
            pgood_prev_q <= 1'b1;
            por_prev_q   <= 1'b1;
            psr_prev_q   <= 1'b1;
        end else begin
            ctrl_q       <= ctrl_d;
            mask_q       <= mask_d;
            ev_q         <= ev_d;
            rdata_q      <= rdata_d;
            rtc_prev_q   <= rtc_s;
            fgood_prev_q <= fgood_s;
            pgood_prev_q <= pgood_s;
            por_prev_q   <= por_s;
            psr_prev_q   <= psr_s;
        end
    end

    assign reg_rdata              = rdata_q;
    assign irq                    = |(ev_q & mask_q);
    assign boot_strap_upper       = ctrl_q[CTRL_UPPER]; // [RL12] [RL13]
    assign boot_strap_lower       = ctrl_q[CTRL_LOWER]; // [RL5]
    assign fabric_supply_enable_n = ctrl_q[CTRL_FEN_N]; // [RL6]

    // ---------------- checks ----------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    logic ctrl_wr;
    assign ctrl_wr = reg_wr && reg_addr == REG_CTRL;

    a_route_soc_pass: assert property ( // [RL1]
        !route_s ##1 !route_s |-> soc_tck == $past(tck_s) && soc_tdi == $past(pin_s[SY_TDI])
    ) else $error("test port not passed to SoC");

    a_route_self_idle: assert property ( // [RL2]
        route_s |=> !soc_tck && soc_tms && carrier_tdo == $past(bypass_q)
    ) else $error("test port not held by controller");

    a_por_follow_req: assert property ( // [RL3]
        !por_s |=> !soc_por_n
    ) else $error("power-on reset request not forwarded");

    a_por_needs_run: assert property ( // [RL15]
        seq_q != MSC_SEQ_RUN |=> !soc_por_n
    ) else $error("SoC released before supplies settled");

    a_hold_length: assert property ( // [RL15]
        $rose(seq_q == MSC_SEQ_HOLD) ##1 supplies_ok [*8] |-> seq_q == MSC_SEQ_HOLD
    ) else $error("hold phase ended early");

    a_psr_follow: assert property ( // [RL4]
        rstn |=> soc_ps_reset_n == $past(psr_s)
    ) else $error("system reset not forwarded");

    a_tdo_pass: assert property ( // [RL1]
        !route_s |=> carrier_tdo == $past(pin_s[SY_STDO])
    ) else $error("SoC test output not passed to carrier");

    a_straps_hold: assert property ( // [RL5]
        !ctrl_wr |=> $stable(boot_strap_lower) && $stable(boot_strap_upper)
    ) else $error("strap moved without a write");

    a_fen_hold: assert property ( // [RL6]
        !ctrl_wr |=> $stable(fabric_supply_enable_n)
    ) else $error("fabric enable moved without a write");

    a_fgood_event: assert property ( // [RL7]
        $changed(fgood_s) |=> ev_q[EV_FGOOD]
    ) else $error("fabric supply change not flagged");

    a_pgood_event: assert property ( // [RL8]
        $changed(pgood_s) |=> ev_q[EV_PGOOD]
    ) else $error("processor supply change not flagged");

    a_rtc_event: assert property ( // [RL10]
        $fell(rtc_s) ##1 mask_q[EV_RTC] |-> irq
    ) else $error("clock interrupt not raised");

    a_led_divider: assert property ( // [RL17]
        $changed(status_led) |-> $past(led_cnt_q) == LED_LAST
    ) else $error("LED toggled off the divider");

    a_boot_qspi: assert property ( // [RL13]
        ctrl_q[CTRL_UPPER] && !pin_s[SY_LOWER] |-> boot_src == MSC_BOOT_QSPI
    ) else $error("straps do not decode as flash boot");

    c_route_swap:  cover property ($fell(route_s) ##[1:20] $rose(route_s));
    c_seq_run:     cover property (seq_q == MSC_SEQ_HOLD ##1 seq_q == MSC_SEQ_RUN);
    c_rtc_irq:     cover property ($fell(rtc_s) ##1 irq);
    c_event_clear: cover property (irq ##1 reg_rd && reg_addr == REG_EVENT ##2 !irq);
endmodule
`default_nettype wire

// *** dv/msc_partner.sv ***
`default_nettype none
// far side model: carrier supplies, on-board clock chip interrupt, soc test-port output
module msc_partner (
    input  wire logic ref_clk,
    input  wire logic power_on,
    input  wire logic rtc_fire,
    output logic      fabric_supply_good_n,
    output logic      processor_supply_good_n,
    output logic      rtc_irq_n,
    output logic      soc_tdo
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] dly_q;
    logic [2:0] rtc_cnt_q;

    initial begin
        dly_q = 4'h0;
        rtc_cnt_q = 3'h0;
        fabric_supply_good_n = 1'b1;
        processor_supply_good_n = 1'b1;
        rtc_irq_n = 1'b1;
        soc_tdo = 1'b0;
    end

    // processor rail settles before the fabric rail, both report low when good
    always @(posedge ref_clk) begin
        dly_q <= {dly_q[2:0], power_on};
        processor_supply_good_n <= ~dly_q[1];
        fabric_supply_good_n <= ~dly_q[3];
    end

    // interrupt is an active low pulse several cycles wide, so the synchroniser sees it
    always @(posedge ref_clk) begin
        if (rtc_fire) begin
            rtc_cnt_q <= 3'h4;
        end else if (rtc_cnt_q != 3'h0) begin
            rtc_cnt_q <= rtc_cnt_q - 3'h1;
        end
        rtc_irq_n <= ~(rtc_fire | (rtc_cnt_q != 3'h0));
    end

    // no scan model behind the port: toggle every cycle so stale data never looks valid
    always @(posedge ref_clk) begin
        soc_tdo <= ~soc_tdo;
    end
endmodule
`default_nettype wire

// *** dv/msc_tb_top.sv ***
`default_nettype none
module msc_tb_top
    import msc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int unsigned HALF = 8;
    logic        ref_clk, rstn, reg_wr, reg_rd, irq, route_select;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, d;
    logic        c_tck, c_tms, c_tdi, carrier_tdo, soc_tck, soc_tms, soc_tdi, soc_tdo;
    logic        por_request_n, soc_por_n, processor_system_reset_in_n, soc_ps_reset_n;
    logic        boot_strap_upper, boot_strap_lower, strap_pin_lower, fabric_supply_enable_n;
    logic        fgood_n, pgood_n, rtc_irq_n, fabric_logic_done, status_led;
    logic        power_on, rtc_fire, led_q;
    logic [31:0] seed;
    logic [3:0]  v;
    int          failures, checks, n;

    msc_top #(.LED_HALF_CYC_P(HALF)) DUT (.ref_clk(ref_clk), .rstn(rstn),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .irq(irq), .route_select(route_select),
        .carrier_tck(c_tck), .carrier_tms(c_tms), .carrier_tdi(c_tdi),
        .carrier_tdo(carrier_tdo), .soc_tck(soc_tck), .soc_tms(soc_tms), .soc_tdi(soc_tdi),
        .soc_tdo(soc_tdo), .por_request_n(por_request_n), .soc_por_n(soc_por_n),
        .processor_system_reset_in_n(processor_system_reset_in_n),
        .soc_ps_reset_n(soc_ps_reset_n), .boot_strap_upper(boot_strap_upper),
        .boot_strap_lower(boot_strap_lower), .strap_pin_lower(strap_pin_lower),
        .fabric_supply_enable_n(fabric_supply_enable_n), .fabric_supply_good_n(fgood_n),
        .processor_supply_good_n(pgood_n), .rtc_irq_n(rtc_irq_n),
        .fabric_logic_done(fabric_logic_done), .status_led(status_led));

    msc_partner PARTNER (.ref_clk(ref_clk), .power_on(power_on), .rtc_fire(rtc_fire),
        .fabric_supply_good_n(fgood_n), .processor_supply_good_n(pgood_n),
        .rtc_irq_n(rtc_irq_n), .soc_tdo(soc_tdo));

    always #10 ref_clk = ~ref_clk;

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    // status layout once the supplies are good and the sequence runs
    function automatic logic [7:0] exp_status(input logic rt, input logic [1:0] boot,
                                              input logic dn);
        return {2'h3, boot, dn, 2'h0, rt};
    endfunction

    task automatic summarize();
        if (failures == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] w);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= w;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    // read data stand only in the cycle after the taking edge
    task automatic rd(input logic [7:0] a, output logic [7:0] r);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        r = reg_rdata;
    endtask

    initial begin
        #200000;
        $display("mismatch at %0t: run timed out", $time);
        failures++;
        summarize();
    end

    initial begin
        ref_clk = 1'b0;
        rstn = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        route_select = 1'b1; // pulled up while open
        c_tck = 1'b0;
        c_tms = 1'b1;
        c_tdi = 1'b1;
        por_request_n = 1'b1;
        processor_system_reset_in_n = 1'b1;
        strap_pin_lower = 1'b0;
        fabric_logic_done = 1'b1;
        power_on = 1'b0;
        rtc_fire = 1'b0;
        seed = 32'h5CAEF528;
        failures = 0;
        checks = 0;
        repeat (4) @(posedge ref_clk);
        rstn <= 1'b1;
        #1;
        chk({1'b0, boot_strap_upper, boot_strap_lower, fabric_supply_enable_n, soc_por_n,
             soc_ps_reset_n, status_led, irq}, 8'h70);
        rd(REG_CTRL, d);
        chk(d, {5'h00, CTRL_RST});
        rd(REG_MASK, d);
        chk(d, 8'h00);
        wr(8'h7F, 8'hA5);
        rd(8'h7F, d);
        chk(d, 8'h00);
        rd(REG_CTRL, d);
        chk(d, 8'h07);
        // carrier holds the route low and powers up; soc reset waits for the hold time
        @(posedge ref_clk);
        route_select <= 1'b0;
        power_on <= 1'b1;
        n = 0;
        while (soc_por_n !== 1'b1 && n < 700) begin
            tick(1);
            n++;
        end
        chk(8'(n >= POR_HOLD_CYC && n <= POR_HOLD_CYC + 20), 8'h01);
        if (n >= 700) begin
            summarize();
        end
        rd(REG_EVENT, d);
        chk(d, 8'((1 << EV_FGOOD) | (1 << EV_PGOOD)));
        rd(REG_STATUS, d);
        chk(d, exp_status(1'b0, 2'h2, 1'b1));
        // interrupt event: masked first, then unmasked, then cleared by the read
        @(posedge ref_clk);
        rtc_fire <= 1'b1;
        @(posedge ref_clk);
        rtc_fire <= 1'b0;
        tick(8);
        chk({7'h00, irq}, 8'h00);
        wr(REG_MASK, 8'(1 << EV_RTC));
        chk({7'h00, irq}, 8'h01);
        rd(REG_EVENT, d);
        chk(d, 8'(1 << EV_RTC));
        chk({7'h00, irq}, 8'h00);
        // second pulse with the mask open raises the line as soon as it is flagged
        @(posedge ref_clk);
        rtc_fire <= 1'b1;
        @(posedge ref_clk);
        rtc_fire <= 1'b0;
        tick(4);
        chk({7'h00, irq}, 8'h01);
        rd(REG_EVENT, d);
        chk(d, 8'(1 << EV_RTC));
        chk({7'h00, irq}, 8'h00);
        // both reset requests reach the soc after two sync flops and one register
        @(posedge ref_clk);
        por_request_n <= 1'b0;
        processor_system_reset_in_n <= 1'b0;
        tick(2);
        chk({6'h00, soc_por_n, soc_ps_reset_n}, 8'h03);
        tick(1);
        chk({6'h00, soc_por_n, soc_ps_reset_n}, 8'h00);
        @(posedge ref_clk);
        por_request_n <= 1'b1;
        processor_system_reset_in_n <= 1'b1;
        tick(3);
        chk({6'h00, soc_por_n, soc_ps_reset_n}, 8'h03);
        rd(REG_EVENT, d);
        chk(d, 8'((1 << EV_POR) | (1 << EV_PSR)));
        // test port passes through with the same three cycle lag
        @(posedge ref_clk);
        c_tck <= 1'b1;
        c_tms <= 1'b0;
        c_tdi <= 1'b0;
        tick(2);
        chk({5'h00, soc_tck, soc_tms, soc_tdi}, 8'h03);
        tick(1);
        chk({5'h00, soc_tck, soc_tms, soc_tdi}, 8'h04);
        // soc output toggles every cycle, so a three cycle lag shows as its inverse
        chk({7'h00, carrier_tdo}, {7'h00, ~soc_tdo});
        // route high: soc sees an idle port, controller bypass bit captures tdi
        @(posedge ref_clk);
        route_select <= 1'b1;
        c_tck <= 1'b0;
        tick(5);
        chk({5'h00, soc_tck, soc_tms, soc_tdi}, 8'h03);
        @(posedge ref_clk);
        c_tck <= 1'b1;
        tick(5);
        chk({7'h00, carrier_tdo}, 8'h00);
        // activity led half period in cycles
        led_q = status_led;
        n = 0;
        while (status_led === led_q && n < 3 * HALF) begin
            tick(1);
            n++;
        end
        led_q = status_led;
        n = 0;
        while (status_led === led_q && n < 3 * HALF) begin
            tick(1);
            n++;
        end
        chk(8'(n), 8'(HALF));
        if (n >= 3 * HALF) begin
            summarize();
        end
        // every boot code by hand, then random straps and control values
        for (int i = 0; i < 12; i++) begin
            v = (i < 4) ? {i[0], 2'b11, i[1]} : seed[3:0];
            seed = xs(seed);
            wr(REG_CTRL, {5'h00, v[2:0]});
            chk({5'h00, fabric_supply_enable_n, boot_strap_lower, boot_strap_upper},
                {5'h00, v[2:0]});
            @(posedge ref_clk);
            strap_pin_lower <= v[3];
            fabric_logic_done <= seed[7];
            tick(3);
            rd(REG_CTRL, d);
            chk(d, {5'h00, v[2:0]});
            rd(REG_STATUS, d);
            chk(d, exp_status(1'b1, {v[0], v[3]}, fabric_logic_done));
        end
        summarize();
    end
endmodule
`default_nettype wire
